/* logic/qaw_defines.vh */
// constants for the question-and-answer watchdog answer checker
`ifndef QAW_DEFINES_VH
`define QAW_DEFINES_VH
// register offsets on the plain register port
`define QAW_ADDR_ANSWER 8'h2e
`define QAW_ADDR_QUESTION 8'h2f
`define QAW_ADDR_STATUS 8'h30
`define QAW_ADDR_CTRL 8'h31
`define QAW_ADDR_FAILCNT 8'h32
// status and control fields
`define QAW_ST_MISMATCH 0
`define QAW_ST_FAIL 1
`define QAW_ST_CNT_LO 4
`define QAW_CTRL_MODE 0
// reset values
`define QAW_CTRL_RESET 8'h00
`define QAW_MODE_RESET 1'b0
`define QAW_QUESTION_RESET 4'h0
`define QAW_THRESHOLD_RESET 4'h5
// answer index runs from first byte down to last
`define QAW_IDX_FIRST 2'b11
`define QAW_IDX_LAST 2'b00
`define QAW_ANSWERS_PER_CYCLE 3'h4
`define QAW_WIN1_NEEDED 3'h3
`endif

/* logic/qaw_answer_checker.v */
// answer checker of the question-and-answer watchdog
`timescale 1ns/100ps
`include "qaw_defines.vh"
//
// Overview of operation
// - four answer bytes enter one answer register, indexed 3 down to 0
// - default settings give a fixed four-byte answer per question value
// - sequence evaluation applies in multi-answer mode, mode select bit zero
// - no answers at all: fail at window two end, same question
// - fourth answer of a cycle ends the cycle at once
// - under four answers at window two end: fail, same question
// - under three correct answers in window one fails the cycle
// - any mismatching byte sets the answer mismatch flag, else clear
// - all four answers in window two: fail, same question
// - three good in window one, one good in two: pass, new question
// - failure count at threshold raises the failure action
module qaw_answer_checker #(
  parameter CNT_W = 4
) (
  input wire clk_in,
  input wire rst_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire win2_in,
  input wire win2_end_in,
  input wire [3:0] next_question_in,
  output reg [7:0] rdata_out,
  output reg [3:0] current_question_value_out,
  output reg cycle_end_out,
  output reg cycle_pass_out,
  output reg fail_action_out
);
  // ==========================================================
  // state
  reg [1:0] answer_index_counter;
  reg [2:0] total_cnt;
  reg [2:0] win1_good;
  reg [2:0] win2_cnt;
  reg answer_mismatch_flag;
  reg watchdog_fail_flag;
  reg cycle_mismatch;
  reg answer_mode_select;
  reg [3:0] failure_threshold_field;
  reg [CNT_W-1:0] fail_cnt;
  reg [7:0] expected;
  // ==========================================================
  // expected answer lookup at default settings
  // key is question in the upper four bits, answer index in the lower two
  // a flat table keeps the byte order visible and needs no function
  // limitation: only the default polynomial and answer settings are held
  always @* begin
    case ({current_question_value_out, answer_index_counter})
      6'h00: expected = 8'h00;
      6'h01: expected = 8'hf0;
      6'h02: expected = 8'h0f;
      6'h03: expected = 8'hff;
      6'h04: expected = 8'h4f;
      6'h05: expected = 8'hbf;
      6'h06: expected = 8'h40;
      6'h07: expected = 8'hb0;
      6'h08: expected = 8'h16;
      6'h09: expected = 8'he6;
      6'h0a: expected = 8'h19;
      6'h0b: expected = 8'he9;
      6'h0c: expected = 8'h59;
      6'h0d: expected = 8'ha9;
      6'h0e: expected = 8'h56;
      6'h0f: expected = 8'ha6;
      6'h10: expected = 8'h8a;
      6'h11: expected = 8'h7a;
      6'h12: expected = 8'h85;
      6'h13: expected = 8'h75;
      6'h14: expected = 8'hc5;
      6'h15: expected = 8'h35;
      6'h16: expected = 8'hca;
      6'h17: expected = 8'h3a;
      6'h18: expected = 8'h9c;
      6'h19: expected = 8'h6c;
      6'h1a: expected = 8'h93;
      6'h1b: expected = 8'h63;
      6'h1c: expected = 8'hd3;
      6'h1d: expected = 8'h23;
      6'h1e: expected = 8'hdc;
      6'h1f: expected = 8'h2c;
      6'h20: expected = 8'h2d;
      6'h21: expected = 8'hdd;
      6'h22: expected = 8'h22;
      6'h23: expected = 8'hd2;
      6'h24: expected = 8'h62;
      6'h25: expected = 8'h92;
      6'h26: expected = 8'h6d;
      6'h27: expected = 8'h9d;
      6'h28: expected = 8'h3b;
      6'h29: expected = 8'hcb;
      6'h2a: expected = 8'h34;
      6'h2b: expected = 8'hc4;
      6'h2c: expected = 8'h74;
      6'h2d: expected = 8'h84;
      6'h2e: expected = 8'h7b;
      6'h2f: expected = 8'h8b;
      6'h30: expected = 8'ha7;
      6'h31: expected = 8'h57;
      6'h32: expected = 8'ha8;
      6'h33: expected = 8'h58;
      6'h34: expected = 8'he8;
      6'h35: expected = 8'h18;
      6'h36: expected = 8'he7;
      6'h37: expected = 8'h17;
      6'h38: expected = 8'hb1;
      6'h39: expected = 8'h41;
      6'h3a: expected = 8'hbe;
      6'h3b: expected = 8'h4e;
      6'h3c: expected = 8'hfe;
      6'h3d: expected = 8'h0e;
      6'h3e: expected = 8'hf1;
      6'h3f: expected = 8'h01;
      default: expected = 8'h00;
    endcase
  end
  // ==========================================================
  // answer evaluation
  wire ans_wr = wr_in && (addr_in == `QAW_ADDR_ANSWER);
  wire ans_ok = (wdata_in == expected);
  wire [2:0] next_total = total_cnt + 3'h1;
  wire last_ans = ans_wr && (next_total == `QAW_ANSWERS_PER_CYCLE);
  // cycle passes only on three good in window one and one good in two
  wire win1_ok_final = (win1_good == `QAW_WIN1_NEEDED);
  wire pass_now = last_ans && win2_in && ans_ok && win1_ok_final &&
    (win2_cnt == 3'h0) && !cycle_mismatch && !answer_mode_select;
  // window two ending before four answers ends the cycle failed
  wire timeout_end = win2_end_in && !last_ans;
  wire end_now = last_ans || timeout_end;
  wire end_mismatch = cycle_mismatch || (ans_wr && !ans_ok);
  // ==========================================================
  // sequencing
  always @(posedge clk_in) begin
    if (rst_in) begin
      answer_index_counter <= `QAW_IDX_FIRST;
      total_cnt <= 3'h0;
      win1_good <= 3'h0;
      win2_cnt <= 3'h0;
      cycle_mismatch <= 1'b0;
      answer_mismatch_flag <= 1'b0;
      watchdog_fail_flag <= 1'b0;
      current_question_value_out <= `QAW_QUESTION_RESET;
      fail_cnt <= {CNT_W{1'b0}};
      cycle_end_out <= 1'b0;
      cycle_pass_out <= 1'b0;
      fail_action_out <= 1'b0;
    end else begin
      cycle_end_out <= end_now;
      cycle_pass_out <= pass_now;
      // level, not pulse: the action logic decides how often to act
      // compare widens the threshold, so any counter width works
      fail_action_out <= (fail_cnt >= failure_threshold_field);
      if (end_now) begin
        answer_index_counter <= `QAW_IDX_FIRST;
        total_cnt <= 3'h0;
        win1_good <= 3'h0;
        win2_cnt <= 3'h0;
        cycle_mismatch <= 1'b0;
        answer_mismatch_flag <= end_mismatch;
        if (pass_now) begin
          watchdog_fail_flag <= 1'b0;
          current_question_value_out <= next_question_in;
          if (fail_cnt != {CNT_W{1'b0}})
            fail_cnt <= fail_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
        end else begin
          watchdog_fail_flag <= 1'b1;
          if (fail_cnt != {CNT_W{1'b1}})
            fail_cnt <= fail_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end else if (ans_wr) begin
        // host ordering across windows is only judged, not enforced
        answer_index_counter <= answer_index_counter - 2'b01;
        total_cnt <= next_total;
        if (!ans_ok)
          cycle_mismatch <= 1'b1;
        // the last answer's own check is in pass_now, so only count here
        if (win2_in) begin
          win2_cnt <= win2_cnt + 3'h1;
        end else if (ans_ok) begin
          win1_good <= win1_good + 3'h1;
        end
      end
    end
  end
  // ==========================================================
  // register port
  always @(posedge clk_in) begin
    if (rst_in) begin
      answer_mode_select <= `QAW_MODE_RESET;
      failure_threshold_field <= `QAW_THRESHOLD_RESET;
    end else if (wr_in && addr_in == `QAW_ADDR_CTRL) begin
      answer_mode_select <= wdata_in[`QAW_CTRL_MODE];
      failure_threshold_field <= wdata_in[7:4];
    end
  end
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `QAW_ADDR_QUESTION: rdata_out <= {4'h0, current_question_value_out};
        `QAW_ADDR_STATUS: rdata_out <= {1'b0, total_cnt, 2'b00,
          watchdog_fail_flag, answer_mismatch_flag};
        `QAW_ADDR_CTRL: rdata_out <= {failure_threshold_field, 3'h0,
          answer_mode_select};
        `QAW_ADDR_FAILCNT: rdata_out <= {{(8-CNT_W){1'b0}}, fail_cnt};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule // qaw_answer_checker

/* test/qaw_answer_checker_props.sv */
// checker for the answer checker port behaviour
`timescale 1ns/100ps
`include "qaw_defines.vh"
module qaw_answer_checker_props (
  input wire clk_in,
  input wire rst_in,
  input wire [7:0] addr_in,
  input wire wr_in,
  input wire win2_in,
  input wire win2_end_in,
  input wire [3:0] next_question_in,
  input wire [3:0] current_question_value_out,
  input wire cycle_end_out,
  input wire cycle_pass_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire ans_wr = wr_in && (addr_in == `QAW_ADDR_ANSWER);
  // window close with no answer in the same cycle
  sequence s_close;
    win2_end_in && !ans_wr;
  endsequence
  a_pass_ends: assert property (cycle_pass_out |-> cycle_end_out)
    else $error("pass without end");
  a_close_fails: assert property (
    s_close |=> cycle_end_out && !cycle_pass_out)
    else $error("window close not a failed end");
  a_keep_quest: assert property (
    cycle_end_out && !cycle_pass_out |->
    $stable(current_question_value_out)) else $error("question changed");
  a_new_quest: assert property (cycle_pass_out |->
    current_question_value_out == $past(next_question_in))
    else $error("new question not taken");
  a_pass_win2: assert property (
    cycle_pass_out |-> $past(ans_wr && win2_in))
    else $error("pass not at window two answer");
  a_end_cause: assert property (
    cycle_end_out |-> $past(ans_wr || win2_end_in))
    else $error("end without cause");
  a_pass_once: assert property (cycle_pass_out |=> !cycle_pass_out)
    else $error("pass too long");
  a_quiet_hold: assert property (!ans_wr && !win2_end_in |=>
    $stable(current_question_value_out)) else $error("question drift");
endmodule // qaw_answer_checker_props
bind qaw_answer_checker qaw_answer_checker_props i_qaw_answer_checker_props (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in),
  .win2_in(win2_in), .win2_end_in(win2_end_in),
  .next_question_in(next_question_in),
  .current_question_value_out(current_question_value_out),
  .cycle_end_out(cycle_end_out), .cycle_pass_out(cycle_pass_out));

/* test/qaw_host_model.sv */
// host model writing answer bytes into the answer register
`timescale 1ns/100ps
module qaw_host_model (
  input wire clk_in,
  input wire go_in,
  input wire [1:0] idx_in,
  input wire bad_in,
  input wire [3:0] q_in,
  output reg wr_out,
  output reg [7:0] wdata_out
);
  reg [31:0] ans;
  // limitation: only questions 0x0 and 0xf are known to this host
  always @* ans = (q_in == 4'hf) ? 32'h01f10efe : 32'hff0ff000;
  initial wr_out = 1'b0;
  initial wdata_out = 8'h00;
  // idle data toggles so a stale byte is never mistaken for an answer
  always @(posedge clk_in) begin
    wr_out <= go_in;
    wdata_out <= go_in ? ans[idx_in*8 +: 8] ^ {8{bad_in}} : ~wdata_out;
  end
endmodule // qaw_host_model

/* test/qaw_answer_checker_tb.sv */
// self-checking bench for the answer checker
`timescale 1ns/100ps
`include "qaw_defines.vh"
module qaw_answer_checker_tb;
  reg clk_in = 1'b0, rst_in = 1'b1, b_wr = 1'b0, rd = 1'b0, win2 = 1'b0;
  reg w2e = 1'b0, go = 1'b0, bad = 1'b0;
  reg [7:0] b_addr = 8'h00, b_data = 8'h00;
  reg [1:0] idx = 2'b11;
  wire h_wr, c_end, c_pass, f_act;
  wire [7:0] h_data, rdata;
  wire [3:0] q;
  integer failures = 0, check_count = 0, cycles = 0;
  always #4 clk_in = ~clk_in;
  qaw_host_model i_qaw_host_model (.clk_in(clk_in), .go_in(go),
    .idx_in(idx), .bad_in(bad), .q_in(q), .wr_out(h_wr), .wdata_out(h_data));
  qaw_answer_checker i_qaw_answer_checker (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(h_wr ? `QAW_ADDR_ANSWER : b_addr),
    .wdata_in(h_wr ? h_data : b_data), .wr_in(h_wr | b_wr), .rd_in(rd),
    .win2_in(win2), .win2_end_in(w2e), .next_question_in(4'hf),
    .rdata_out(rdata), .current_question_value_out(q),
    .cycle_end_out(c_end), .cycle_pass_out(c_pass), .fail_action_out(f_act));
  task chk(input logic [7:0] seen, input logic [7:0] exp, input [47:0] what);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task rd_reg(input [7:0] a, input [7:0] e);
    begin
      b_addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      #1 rd <= 1'b0;
      chk(rdata, e, "rdata");
      @(posedge clk_in);
      #1;
    end
  endtask
  task put(input [1:0] i, input bd);
    begin
      idx <= i;
      bad <= bd;
      go <= 1'b1;
      @(posedge clk_in);
      #1 go <= 1'b0;
      @(posedge clk_in);
      #1;
    end
  endtask
  // status 8'hff marks a cycle whose end is not judged
  task cyc(input integer n1, input integer n2, input bd, input ep,
    input [7:0] est);
    integer k;
    reg [3:0] q0;
    begin
      q0 = q;
      for (k = 0; k < n1 + n2; k = k + 1) begin
        win2 <= (k >= n1);
        put(2'd3 - k[1:0], bd && k == 3);
      end
      if (n1 + n2 < 4) begin
        win2 <= 1'b1;
        w2e <= 1'b1;
        @(posedge clk_in);
        #1 w2e <= 1'b0;
      end
      chk(c_pass, ep, "pass");
      if (est !== 8'hff) begin
        chk(c_end, 1'b1, "end");
        chk(q, ep ? 4'hf : q0, "quest");
        rd_reg(`QAW_ADDR_STATUS, est);
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rst_in <= 1'b0;
    rd_reg(`QAW_ADDR_QUESTION, 8'h00);
    rd_reg(8'h00, 8'h00);
    cyc(3, 1, 0, 1, 8'h00);
    cyc(3, 1, 1, 0, 8'h03);
    cyc(0, 4, 0, 0, 8'h02);
    cyc(0, 0, 0, 0, 8'h02);
    cyc(2, 1, 0, 0, 8'h02);
    rd_reg(`QAW_ADDR_FAILCNT, 8'h04);
    chk(f_act, 1'b0, "action");
    cyc(0, 0, 0, 0, 8'h02);
    chk(f_act, 1'b1, "action");
    b_addr <= `QAW_ADDR_CTRL;
    b_data <= 8'h51;
    b_wr <= 1'b1;
    @(posedge clk_in);
    #1 b_wr <= 1'b0;
    cyc(3, 1, 0, 0, 8'hff);
    end_sim;
  end
  // a hang is cut short well above the roughly 64 cycles needed
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      end_sim;
    end
  end
endmodule // qaw_answer_checker_tb
